//--- core/run_cmd_consts.vh
// Purpose: Shared constants for the run command input decoder.
// Assumes: 32-bit AXI4-Lite register words at byte offsets.
// Notes:   Timing figures are in their own units; cycle counts are derived.
`ifndef RUN_CMD_CONSTS_VH
`define RUN_CMD_CONSTS_VH

// Register byte offsets.
`define REG_CTRL_OFS        8'h00
`define REG_STATUS_OFS      8'h04
`define REG_INPUTS_OFS      8'h08

// Control register fields and reset value.
`define CTRL_RESTART_EN_BIT 0
`define CTRL_RESET_VAL      32'h00000000

// Status register fields.
`define ST_RUN_FWD_BIT      0
`define ST_RUN_REV_BIT      1
`define ST_JOG_BIT          2
`define ST_ALT_PARAM_BIT    3
`define ST_OUTPUT_OFF_BIT   4
`define ST_CUR_INPUT_BIT    5
`define ST_RESTART_ARM_BIT  6
`define ST_RUN_HELD_BIT     7
`define ST_SPEED_LSB        8

// AXI response codes.
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

// Timing.
`define CLK_MHZ             250
`define DEBOUNCE_NS         10000
`define DEBOUNCE_CYCLES     ((`DEBOUNCE_NS * `CLK_MHZ + 999) / 1000)
`define SHUTOFF_MIN_MS      20
`define SHUTOFF_CYCLES      (`SHUTOFF_MIN_MS * `CLK_MHZ * 1000)

`endif

//--- core/contact_debounce.v
// Purpose: Synchronise one contact input and reject bounce.
// Assumes: Input is asynchronous to aclk.
// Notes:   Output follows the pin after CYCLES stable samples.
`timescale 1ns/1ps
`default_nettype none
module contact_debounce #(
    parameter         CNT_W  = 12,
    parameter [11:0]  CYCLES = 12'd2500
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       pin,
    output reg        level
);
    reg             sync1_reg;
    reg             sync2_reg;
    reg [CNT_W-1:0] cnt_reg;

    // Two-stage synchroniser; only the second stage feeds logic.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
        end
    end

    // A differing sample must persist the whole window to be accepted.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_reg <= {CNT_W{1'b0}};
            level   <= 1'b0;
        end
        else if (sync2_reg == level)
            cnt_reg <= {CNT_W{1'b0}};
        else if (cnt_reg == CYCLES - 12'd1)
        begin
            cnt_reg <= {CNT_W{1'b0}};
            level   <= sync2_reg;
        end
        else
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
endmodule // contact_debounce
`default_nettype wire

//--- core/hold_qualifier.v
// Purpose: Assert a flag only after a level has been held long enough.
// Assumes: Input is already synchronous and debounced.
// Notes:   Flag drops in the cycle after the level drops.
`timescale 1ns/1ps
`default_nettype none
module hold_qualifier #(
    parameter         CNT_W  = 23,
    parameter integer CYCLES = 5000000
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       level,
    output reg        held
);
    // The last count is cut to the counter width on purpose.
    localparam integer     LAST_INT = CYCLES - 1;
    localparam [CNT_W-1:0] LAST     = LAST_INT[CNT_W-1:0];

    reg [CNT_W-1:0] cnt_reg;

    // Count the held time and saturate once it is reached.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_reg <= {CNT_W{1'b0}};
            held    <= 1'b0;
        end
        else if (!level)
        begin
            cnt_reg <= {CNT_W{1'b0}};
            held    <= 1'b0;
        end
        else if (cnt_reg == LAST)
            held    <= 1'b1;
        else
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
endmodule // hold_qualifier
`default_nettype wire

//--- core/run_command_input_decoder.v
// Purpose: Decode drive contact inputs into motor commands.
// Assumes: Pins are asynchronous; power_restored is a same-clock pulse.
// Notes:   Registers reached over AXI4-Lite, 32-bit aligned words.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "run_cmd_consts.vh"
`default_nettype none
module run_command_input_decoder #(
    parameter         ADDR_W         = 8,
    parameter integer SHUTOFF_CYCLES = `SHUTOFF_CYCLES
) (
    input  wire              aclk,
    input  wire              aresetn,
    // Contact inputs from the external controller.
    input  wire              forward_run_cmd,
    input  wire              reverse_run_cmd,
    input  wire              run_hold_select,
    input  wire              speed_select_high,
    input  wire              speed_select_mid,
    input  wire              speed_select_low,
    input  wire              jog_select,
    input  wire              second_param_set_select,
    input  wire              output_shutoff,
    input  wire              current_input_enable,
    input  wire              restart_enable,
    // Power return event from the supply monitor.
    input  wire              power_restored,
    // Commands to the motor control core.
    output reg               run_forward,
    output reg               run_reverse,
    output reg               stop_pulse,
    output reg               jog_mode,
    output reg  [2:0]        preset_speed,
    output reg               alt_param_set,
    output reg               output_off,
    output reg               select_current_input,
    output reg               restart_request,
    // AXI4-Lite slave.
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready
);
    // Positions of the contacts in the debounced vector.
    localparam integer N_IN  = 11;
    localparam integer I_FWD = 0;
    localparam integer I_REV = 1;
    localparam integer I_HLD = 2;
    localparam integer I_SPH = 3;
    localparam integer I_SPM = 4;
    localparam integer I_SPL = 5;
    localparam integer I_JOG = 6;
    localparam integer I_ALT = 7;
    localparam integer I_OFF = 8;
    localparam integer I_CUR = 9;
    localparam integer I_RST = 10;
    // The window is cut to the filter's counter width on purpose.
    localparam integer DB_INT    = `DEBOUNCE_CYCLES;
    localparam [11:0]  DB_CYCLES = DB_INT[11:0];

    wire [N_IN-1:0] pins;
    wire [N_IN-1:0] db;
    wire            shutoff_held;

    reg             fwd_prev_reg;
    reg             rev_prev_reg;
    reg             hold_fwd_reg;
    reg             hold_rev_reg;
    reg             hold_fwd_next;
    reg             hold_rev_next;
    reg             run_fwd_next;
    reg             run_rev_next;
    reg [31:0]      ctrl_reg;

    reg             aw_have_reg;
    reg             w_have_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg [31:0]      w_data_reg;
    reg [3:0]       w_strb_reg;
    reg [31:0]      rdata_next;
    reg [1:0]       rresp_next;

    wire            fwd_rise;
    wire            rev_rise;
    wire            restart_armed;
    wire            do_write;

    assign pins = {restart_enable, current_input_enable, output_shutoff,
                   second_param_set_select, jog_select, speed_select_low,
                   speed_select_mid, speed_select_high, run_hold_select,
                   reverse_run_cmd, forward_run_cmd};

    // Every contact gets its own synchroniser and bounce filter.
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi = gi + 1)
        begin : g_db
            contact_debounce #(
                .CNT_W  (12),
                .CYCLES (DB_CYCLES)
            ) u_db (
                .aclk    (aclk),
                .aresetn (aresetn),
                .pin     (pins[gi]),
                .level   (db[gi])
            );
        end
    endgenerate

    // Short shutoff pulses are treated as noise, not as a command.
    hold_qualifier #(
        .CNT_W  (23),
        .CYCLES (SHUTOFF_CYCLES)
    ) u_shutoff (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   (db[I_OFF]),
        .held    (shutoff_held)
    );

    assign fwd_rise = db[I_FWD] & ~fwd_prev_reg;
    assign rev_rise = db[I_REV] & ~rev_prev_reg;

    // The hold latch keeps the last momentary run direction while the
    // hold select is on, unless both run contacts close at once; dropping
    // hold select releases it, which is how a three-wire stop button works.
    always @*
    begin
        hold_fwd_next = hold_fwd_reg;
        hold_rev_next = hold_rev_reg;
        if (!db[I_HLD] || (db[I_FWD] && db[I_REV]))
        begin
            hold_fwd_next = 1'b0;
            hold_rev_next = 1'b0;
        end
        else if (fwd_rise)
        begin
            hold_fwd_next = 1'b1;
            hold_rev_next = 1'b0;
        end
        else if (rev_rise)
        begin
            hold_fwd_next = 1'b0;
            hold_rev_next = 1'b1;
        end
    end

    // Direction decode; both directions at once decode to stop.
    always @*
    begin
        run_fwd_next = (db[I_FWD] | hold_fwd_next)
                     & ~(db[I_REV] | hold_rev_next);
        run_rev_next = (db[I_REV] | hold_rev_next)
                     & ~(db[I_FWD] | hold_fwd_next);
    end

    assign restart_armed = db[I_RST] & ctrl_reg[`CTRL_RESTART_EN_BIT];

    // Command outputs, all registered.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fwd_prev_reg         <= 1'b0;
            rev_prev_reg         <= 1'b0;
            hold_fwd_reg         <= 1'b0;
            hold_rev_reg         <= 1'b0;
            run_forward          <= 1'b0;
            run_reverse          <= 1'b0;
            stop_pulse           <= 1'b0;
            jog_mode             <= 1'b0;
            preset_speed         <= 3'h0;
            alt_param_set        <= 1'b0;
            output_off           <= 1'b0;
            select_current_input <= 1'b0;
            restart_request      <= 1'b0;
        end
        else
        begin
            fwd_prev_reg  <= db[I_FWD];
            rev_prev_reg  <= db[I_REV];
            hold_fwd_reg  <= hold_fwd_next;
            hold_rev_reg  <= hold_rev_next;
            run_forward   <= run_fwd_next;
            run_reverse   <= run_rev_next;
            // One pulse whenever running ends, except when reset ends it.
            stop_pulse    <= (run_forward | run_reverse)
                           & ~(run_fwd_next | run_rev_next);
            // Jog is only meaningful once a run direction is given.
            jog_mode      <= db[I_JOG] & (run_fwd_next | run_rev_next);
            preset_speed  <= {db[I_SPH], db[I_SPM], db[I_SPL]};
            alt_param_set <= db[I_ALT];
            output_off    <= shutoff_held;
            select_current_input <= db[I_CUR];
            restart_request <= power_restored & restart_armed;
        end
    end

    assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;

    // Write channel: address and data are taken in either order and the
    // response follows once both are in hand.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= {ADDR_W{1'b0}};
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            ctrl_reg      <= `CTRL_RESET_VAL;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg[7:0] == `REG_CTRL_OFS)
                begin
                    s_axi_bresp <= `RESP_OKAY;
                    if (w_strb_reg[0])
                        ctrl_reg[`CTRL_RESTART_EN_BIT] <=
                            w_data_reg[`CTRL_RESTART_EN_BIT];
                end
                else if (aw_addr_reg[7:0] == `REG_STATUS_OFS ||
                         aw_addr_reg[7:0] == `REG_INPUTS_OFS)
                    s_axi_bresp <= `RESP_OKAY;
                else
                    s_axi_bresp <= `RESP_SLVERR;
            end
            // Ready again only after the response is taken, so that at
            // most one write is in flight.
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read data mux; unmapped words read zero with an error response.
    always @*
    begin
        rdata_next = 32'h00000000;
        rresp_next = `RESP_OKAY;
        case (s_axi_araddr[7:0])
            `REG_CTRL_OFS:
                rdata_next = ctrl_reg;
            `REG_STATUS_OFS:
            begin
                rdata_next[`ST_RUN_FWD_BIT]     = run_forward;
                rdata_next[`ST_RUN_REV_BIT]     = run_reverse;
                rdata_next[`ST_JOG_BIT]         = jog_mode;
                rdata_next[`ST_ALT_PARAM_BIT]   = alt_param_set;
                rdata_next[`ST_OUTPUT_OFF_BIT]  = output_off;
                rdata_next[`ST_CUR_INPUT_BIT]   = select_current_input;
                rdata_next[`ST_RESTART_ARM_BIT] = restart_armed;
                rdata_next[`ST_RUN_HELD_BIT]    = hold_fwd_reg | hold_rev_reg;
                rdata_next[`ST_SPEED_LSB+2:`ST_SPEED_LSB] = preset_speed;
            end
            `REG_INPUTS_OFS:
                rdata_next[N_IN-1:0] = db;
            default:
                rresp_next = `RESP_SLVERR;
        endcase
    end

    // Read channel: data is captured at the address handshake.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_next;
            s_axi_rresp   <= rresp_next;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // run_command_input_decoder
`default_nettype wire

//--- bench/contact_bank.sv
// Purpose: Relay contact bank that drives the decoder's contact pins.
// Assumes: The bench sets the wanted contact state on target.
// Notes:   Each change chatters for eight clocks before it settles.
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
    input  wire logic        aclk,
    input  wire logic [10:0] target,
    output wire logic [10:0] pins
);
    logic [10:0] now_val = 11'h000;
    logic [10:0] old_val = 11'h000;
    logic [3:0]  bounce  = 4'h0;
    // Real contacts chatter, so old and new states alternate for a while.
    always @(posedge aclk)
    begin
        if (target != now_val)
        begin
            old_val <= now_val;
            now_val <= target;
            bounce  <= 4'h8;
        end
        else if (bounce != 4'h0)
            bounce <= bounce - 4'h1;
    end
    assign pins = bounce[0] ? old_val : now_val;
endmodule // contact_bank
`default_nettype wire

//--- bench/run_cmd_monitor.sv
// Purpose: Port checker for the run command decoder.
// Assumes: One clock, aresetn synchronous and active low.
// Notes:   Counters stand in for long stable pin windows.
`timescale 1ns/1ps
`default_nettype none
module run_cmd_monitor #(
    parameter integer SHUTOFF_CYCLES = 50
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        forward_run_cmd,
    input wire logic        output_shutoff,
    input wire logic        power_restored,
    input wire logic        run_forward,
    input wire logic        run_reverse,
    input wire logic        stop_pulse,
    input wire logic        jog_mode,
    input wire logic        output_off,
    input wire logic        restart_request,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] fwd_cnt;
    logic [15:0] off_cnt;
    logic        cfg_seen;
    // Counters saturate, so a long hold never wraps back to a small value.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fwd_cnt  <= 16'h0000;
            off_cnt  <= 16'h0000;
            cfg_seen <= 1'b0;
        end
        else
        begin
            fwd_cnt  <= forward_run_cmd ? fwd_cnt + {15'h0000, ~&fwd_cnt} : 16'h0000;
            off_cnt  <= output_shutoff ? off_cnt + {15'h0000, ~&off_cnt} : 16'h0000;
            cfg_seen <= cfg_seen | (s_axi_bvalid & s_axi_bready);
        end
    end
    sequence s_run_end;
        ($fell(run_forward) && !run_reverse) || ($fell(run_reverse) && !run_forward);
    endsequence
    sequence s_stop;
        ##[0:1] stop_pulse;
    endsequence
    property p_stop; s_run_end |-> s_stop; endproperty
    property p_excl; !(run_forward && run_reverse); endproperty
    property p_pulse; stop_pulse |=> !stop_pulse; endproperty
    property p_jog; jog_mode |-> run_forward || run_reverse || $past(run_forward)
        || $past(run_reverse); endproperty
    property p_rst_cause; restart_request |-> $past(power_restored); endproperty
    property p_rst_cfg; restart_request |-> cfg_seen; endproperty
    property p_debounce; $rose(run_forward) |-> fwd_cnt >= 16'h0960; endproperty
    property p_shutoff; $rose(output_off) |-> off_cnt >= SHUTOFF_CYCLES + 2400; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp); endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata); endproperty
    a_stop: assert property (p_stop) else $error("no stop pulse at run end");
    a_excl: assert property (p_excl) else $error("both directions run");
    a_pulse: assert property (p_pulse) else $error("stop pulse too long");
    a_jog: assert property (p_jog) else $error("jog without run");
    a_rst_cause: assert property (p_rst_cause) else $error("restart without power");
    a_rst_cfg: assert property (p_rst_cfg) else $error("restart before config");
    a_debounce: assert property (p_debounce) else $error("run before debounce");
    a_shutoff: assert property (p_shutoff) else $error("shutoff too early");
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule // run_cmd_monitor
bind run_command_input_decoder run_cmd_monitor #(.SHUTOFF_CYCLES(SHUTOFF_CYCLES)) i_mon (
    .aclk, .aresetn, .forward_run_cmd, .output_shutoff, .power_restored, .run_forward,
    .run_reverse, .stop_pulse, .jog_mode, .output_off, .restart_request, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

//--- bench/run_command_input_decoder_test.sv
// Purpose: Self-checking bench for the run command decoder.
// Assumes: A contact change settles within SETTLE clocks.
// Notes:   Shutoff qualification is cut to 50 clocks.
`timescale 1ns/1ps
`default_nettype none
module run_command_input_decoder_test;
    localparam int SETTLE = 2700;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        power_restored = 1'b0;
    logic [10:0] tgt = 11'h000;
    wire  [10:0] pins;
    logic        run_forward, run_reverse, stop_pulse, jog_mode, alt_param_set;
    logic        output_off, select_current_input, restart_request;
    logic [2:0]  preset_speed;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_seen = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int          mismatches = 0;
    int          n_tests = 0;
    contact_bank i_bank (.aclk, .target(tgt), .pins);
    run_command_input_decoder #(.SHUTOFF_CYCLES(50)) i_dut (
        .aclk, .aresetn, .power_restored, .forward_run_cmd(pins[0]),
        .reverse_run_cmd(pins[1]), .run_hold_select(pins[2]), .speed_select_high(pins[3]),
        .speed_select_mid(pins[4]), .speed_select_low(pins[5]), .jog_select(pins[6]),
        .second_param_set_select(pins[7]), .output_shutoff(pins[8]),
        .current_input_enable(pins[9]), .restart_enable(pins[10]), .run_forward,
        .run_reverse, .stop_pulse, .jog_mode, .preset_speed, .alt_param_set, .output_off,
        .select_current_input, .restart_request, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // Clock at 250 MHz.
    initial
    begin
        forever #2 aclk = ~aclk;
    end
    // Stop lasts one cycle, so it is caught here and judged later.
    always @(posedge aclk)
        if (stop_pulse === 1'b1) stop_seen <= 1'b1;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Contacts change and then the bench waits out debounce and chatter.
    task automatic set_pins(input logic [10:0] v);
        @(posedge aclk);
        tgt <= v;
        stop_seen <= 1'b0;
        repeat (SETTLE) @(posedge aclk);
        #1;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        chk("bvalid", s_axi_bvalid, 32'h1);
        chk("bresp", s_axi_bresp, 32'h0);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk("rvalid", s_axi_rvalid, 32'h1);
    endtask
    // The pulse is sampled at edge k+1, and the answer stands until edge k+2.
    task automatic pulse(input logic exp);
        @(posedge aclk);
        power_restored <= 1'b1;
        @(posedge aclk);
        power_restored <= 1'b0;
        #1;
        chk("restart_request", restart_request, exp);
    endtask
    task automatic t_run();
        set_pins(11'h001);
        chk("run_forward", run_forward, 1);
        set_pins(11'h000);
        chk("stop", {run_forward, stop_seen}, 1);
        set_pins(11'h002);
        chk("run_reverse", run_reverse, 1);
        set_pins(11'h003);
        chk("both", {run_forward, run_reverse, stop_seen}, 1);
        set_pins(11'h000);
    endtask
    task automatic t_hold();
        set_pins(11'h004);
        set_pins(11'h005);
        set_pins(11'h004);
        chk("held", run_forward, 1);
        set_pins(11'h000);
        chk("unheld", {run_forward, stop_seen}, 1);
    endtask
    // Jog select goes on before the run contact, as the drive expects.
    task automatic t_jog();
        set_pins(11'h040);
        chk("jog_idle", jog_mode, 0);
        set_pins(11'h041);
        chk("jog", {jog_mode, run_forward}, 3);
        set_pins(11'h000);
    endtask
    task automatic t_speed();
        logic [2:0] c;
        for (int i = 1; i <= 8; i++)
        begin
            c = i[2:0];
            set_pins({5'h00, c[0], c[1], c[2], 3'h0});
            chk("preset_speed", preset_speed, c);
        end
    endtask
    // Shutoff stays on for the whole settle span, well past its minimum.
    task automatic t_misc();
        set_pins(11'h380);
        chk("alt", alt_param_set, 1);
        chk("cur", select_current_input, 1);
        chk("off", output_off, 1);
        axi_rd(8'h08);
        chk("inputs", rd, 32'h380);
        set_pins(11'h000);
        chk("clear", {alt_param_set, select_current_input, output_off}, 0);
    endtask
    task automatic t_regs();
        axi_rd(8'h00);
        chk("ctrl_reset", rd, 0);
        axi_rd(8'h0c);
        chk("unmapped_resp", rr, 32'h2);
        chk("unmapped_data", rd, 32'h0);
        set_pins(11'h400);
        pulse(1'b0);
        axi_wr(8'h00, 32'h1);
        axi_wr(8'h04, 32'hffffffff);
        axi_rd(8'h04);
        chk("status", rd, 32'h40);
        pulse(1'b1);
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_run();
        t_hold();
        t_jog();
        t_speed();
        t_misc();
        t_regs();
        summarize();
    end
    // Watchdog well beyond the roughly 62000 clocks the tests need.
    initial
    begin
        #(4 * 90000);
        mismatches++;
        summarize();
    end
endmodule // run_command_input_decoder_test
`default_nettype wire
